// >>> core/plp_top.sv
`timescale 1ns/1ps

// Small synchronous FIFO with valid/ready on both sides
module plp_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o,
  output logic [AW:0]           level_o
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      level_q;
  logic             push;
  logic             pop;

  // Honest full and empty from the level count
  assign in_ready_o  = (level_q != (AW+1)'(DEPTH));
  assign out_valid_o = (level_q != '0);
  assign out_data_o  = mem[rd_ptr_q];
  assign level_o     = level_q;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Storage
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data_i;
    end
  end

  // Pointers and level
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      level_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      level_q <= level_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module plp_top #(
  parameter int unsigned ENTRIES    = plp_pkg::ENTRIES,
  parameter int unsigned FIFO_DEPTH = plp_pkg::FIFO_DEPTH
) (
  input  wire logic                       clock_i,
  input  wire logic                       resetn_i,
  input  wire logic [7:0]                 pixel_index_i,
  input  wire logic                       video_suppress_n_i,
  input  wire logic                       pixel_valid_i,
  output logic                            pixel_ready_o,
  output plp_pkg::plp_color_s             color_o,
  output logic                            color_valid_o,
  input  wire logic                       color_ready_i,
  input  wire logic                       host_rd_n_i,
  input  wire logic                       host_wr_n_i,
  input  wire logic [1:0]                 host_reg_select_i,
  input  wire logic [7:0]                 host_data_bus_i,
  output logic [7:0]                      host_data_bus_o,
  output logic                            host_data_bus_oe_o
);
  localparam int unsigned LW = $clog2(FIFO_DEPTH) + 1;

  plp_pkg::plp_color_s palette [ENTRIES];
  plp_pkg::plp_pixel_s pix_q;
  plp_pkg::plp_color_s look_q;
  plp_pkg::plp_color_s pal_word;
  plp_pkg::plp_phase_e phase_q;
  logic       pix_valid_q;
  logic       look_valid_q;
  logic       fifo_ready;
  logic [LW-1:0] level;
  logic [7:0] mask_q;
  logic [7:0] addr_q;
  logic [5:0] red_q;
  logic [5:0] green_q;
  logic [2:0] rd_n_sync_q;
  logic [2:0] wr_n_sync_q;
  logic [1:0] sel_s1_q;
  logic [1:0] sel_s2_q;
  logic [7:0] dat_s1_q;
  logic [7:0] dat_s2_q;
  logic [7:0] wr_data_q;
  logic [1:0] wr_sel_q;
  logic [1:0] rd_sel_q;
  logic       wr_rise;
  logic       rd_fall;
  logic       rd_rise;

  // Host pins pass two flops; bit 2 is the edge history
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rd_n_sync_q <= 3'h7;
      wr_n_sync_q <= 3'h7;
      sel_s1_q    <= '0;
      sel_s2_q    <= '0;
      dat_s1_q    <= '0;
      dat_s2_q    <= '0;
    end else begin
      rd_n_sync_q <= {rd_n_sync_q[1:0], host_rd_n_i};
      wr_n_sync_q <= {wr_n_sync_q[1:0], host_wr_n_i};
      sel_s1_q    <= host_reg_select_i;
      sel_s2_q    <= sel_s1_q;
      dat_s1_q    <= host_data_bus_i;
      dat_s2_q    <= dat_s1_q;
    end
  end

  assign wr_rise = wr_n_sync_q[1] & ~wr_n_sync_q[2];
  assign rd_fall = ~rd_n_sync_q[1] & rd_n_sync_q[2];
  assign rd_rise = rd_n_sync_q[1] & ~rd_n_sync_q[2];

  // Track bus data while the write strobe is low
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      wr_data_q <= '0;
      wr_sel_q  <= '0;
    end else if (!wr_n_sync_q[1] && rd_n_sync_q[1]) begin
      wr_data_q <= dat_s2_q;
      wr_sel_q  <= sel_s2_q;
    end
  end

  // Address register, colour phase and shadow components
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      addr_q  <= plp_pkg::ADDR_RESET;
      phase_q <= plp_pkg::PH_RED;
      red_q   <= '0;
      green_q <= '0;
    end else if (wr_rise && rd_n_sync_q[1]) begin
      case (wr_sel_q)
        plp_pkg::SEL_ADDR_WR, plp_pkg::SEL_ADDR_RD: begin
          addr_q  <= wr_data_q;
          phase_q <= plp_pkg::PH_RED;
        end
        plp_pkg::SEL_PALETTE: begin
          case (phase_q)
            plp_pkg::PH_RED: begin
              red_q   <= wr_data_q[5:0];
              phase_q <= plp_pkg::PH_GREEN;
            end
            plp_pkg::PH_GREEN: begin
              green_q <= wr_data_q[5:0];
              phase_q <= plp_pkg::PH_BLUE;
            end
            default: begin
              addr_q  <= addr_q + plp_pkg::ADDR_ONE; // Wraps FF to 00
              phase_q <= plp_pkg::PH_RED;
            end
          endcase
        end
        default: begin
        end
      endcase
    end else if (rd_rise && wr_n_sync_q[1]
                 && rd_sel_q == plp_pkg::SEL_PALETTE) begin
      case (phase_q)
        plp_pkg::PH_RED:   phase_q <= plp_pkg::PH_GREEN;
        plp_pkg::PH_GREEN: phase_q <= plp_pkg::PH_BLUE;
        default: begin
          addr_q  <= addr_q + plp_pkg::ADDR_ONE;
          phase_q <= plp_pkg::PH_RED;
        end
      endcase
    end
  end

  // Blue write commits the 18-bit entry
  always_ff @(posedge clock_i) begin
    if (wr_rise && rd_n_sync_q[1] && wr_sel_q == plp_pkg::SEL_PALETTE
        && phase_q == plp_pkg::PH_BLUE) begin
      palette[addr_q] <= {red_q, green_q, wr_data_q[5:0]};
    end
  end

  // Pixel mask register
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      mask_q <= plp_pkg::MASK_RESET;
    end else if (wr_rise && rd_n_sync_q[1]
                 && wr_sel_q == plp_pkg::SEL_MASK) begin
      mask_q <= wr_data_q;
    end
  end

  assign pal_word = palette[addr_q];

  // Read data latched at the falling read strobe, bus driven while low
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      host_data_bus_o    <= '0;
      host_data_bus_oe_o <= 1'b0;
      rd_sel_q           <= '0;
    end else begin
      host_data_bus_oe_o <= ~rd_n_sync_q[1] & wr_n_sync_q[1];
      if (rd_fall && wr_n_sync_q[1]) begin
        rd_sel_q <= sel_s2_q;
        case (sel_s2_q)
          plp_pkg::SEL_PALETTE: begin
            case (phase_q)
              plp_pkg::PH_RED:
                host_data_bus_o <= {plp_pkg::TOP_ZERO, pal_word.red};
              plp_pkg::PH_GREEN:
                host_data_bus_o <= {plp_pkg::TOP_ZERO, pal_word.green};
              default:
                host_data_bus_o <= {plp_pkg::TOP_ZERO, pal_word.blue};
            endcase
          end
          plp_pkg::SEL_MASK: host_data_bus_o <= mask_q;
          default:           host_data_bus_o <= addr_q;
        endcase
      end
    end
  end

  // Pixel capture each clock edge
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pix_q       <= '0;
      pix_valid_q <= 1'b0;
    end else begin
      pix_valid_q      <= pixel_valid_i & pixel_ready_o;
      pix_q.suppress_n <= video_suppress_n_i;
      pix_q.index      <= pixel_index_i;
    end
  end

  // Masked lookup, or blanking level when suppressed
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      look_q       <= '0;
      look_valid_q <= 1'b0;
    end else begin
      look_valid_q <= pix_valid_q;
      if (!pix_q.suppress_n) begin
        look_q <= {plp_pkg::BLANK_LVL, plp_pkg::BLANK_LVL,
                   plp_pkg::BLANK_LVL};
      end else begin
        look_q <= palette[pix_q.index & mask_q];
      end
    end
  end

  // Leave room for the pixels already in the pipeline: ready lags the
  // level by two edges and three stages are in flight, so five slots
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pixel_ready_o <= 1'b0;
    end else begin
      pixel_ready_o <= (level <= LW'(FIFO_DEPTH - 5));
    end
  end

  plp_fifo #(
    .WIDTH (plp_pkg::COLOR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (look_valid_q),
    .in_ready_o  (fifo_ready),
    .in_data_i   (look_q),
    .out_valid_o (color_valid_o),
    .out_ready_i (color_ready_i),
    .out_data_o  (color_o),
    .level_o     (level)
  );
endmodule

// >>> core/plp_pkg.sv
package plp_pkg;
  // Host data, pixel index and colour widths
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned INDEX_W = 8;
  localparam int unsigned COMP_W  = 6;
  localparam int unsigned ENTRIES = 256;

  // Register select codes
  localparam logic [1:0] SEL_ADDR_WR = 2'h0;
  localparam logic [1:0] SEL_PALETTE = 2'h1;
  localparam logic [1:0] SEL_MASK    = 2'h2;
  localparam logic [1:0] SEL_ADDR_RD = 2'h3;

  // Reset values and fixed constants
  localparam logic [7:0] MASK_RESET = 8'hff;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] ADDR_ONE   = 8'h01;
  localparam logic [5:0] BLANK_LVL  = 6'h00;
  localparam logic [1:0] TOP_ZERO   = 2'h0;

  // Colour phase counts modulo three
  typedef enum logic [1:0] {
    PH_RED   = 2'b00,
    PH_GREEN = 2'b01,
    PH_BLUE  = 2'b10
  } plp_phase_e;

  typedef struct packed {
    logic       suppress_n;
    logic [7:0] index;
  } plp_pixel_s;

  typedef struct packed {
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
  } plp_color_s;

  localparam int unsigned COLOR_W = $bits(plp_color_s);
  localparam int unsigned FIFO_DEPTH = 8;
endpackage

// >>> dv/plp_checker.sv
`timescale 1ns/1ps
// Port watch of the pixel path and the host read driver
module plp_checker (
  input wire logic                clock_i,
  input wire logic                resetn_i,
  input wire logic                pixel_valid_i,
  input wire logic                pixel_ready_o,
  input wire plp_pkg::plp_color_s color_o,
  input wire logic                color_valid_o,
  input wire logic                color_ready_i,
  input wire logic                host_rd_n_i,
  input wire logic                host_wr_n_i,
  input wire logic [1:0]          host_reg_select_i,
  input wire logic [7:0]          host_data_bus_o,
  input wire logic                host_data_bus_oe_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // Pixel path and colour queue head
  a_take_valid: assert property (pixel_valid_i && pixel_ready_o |->
    ##[3:4] color_valid_o) else $error("colour late");
  a_head_hold: assert property (color_valid_o && !color_ready_i |=>
    color_valid_o && $stable(color_o)) else $error("head moved");
  a_ready_room: assert property ($past(resetn_i) && $past(resetn_i, 2) &&
    !pixel_ready_o |-> color_valid_o) else $error("ready low when empty");
  // Host read driver
  a_oe_rise: assert property ($fell(host_rd_n_i) && host_wr_n_i |->
    ##[2:4] host_data_bus_oe_o) else $error("bus not driven");
  a_oe_cause: assert property ($rose(host_data_bus_oe_o) |->
    !$past(host_rd_n_i, 3)) else $error("drive without read");
  a_oe_drop: assert property ($rose(host_rd_n_i) |->
    ##[1:4] !host_data_bus_oe_o) else $error("bus not released");
  a_rd_quiet: assert property (host_rd_n_i [*5] |->
    !host_data_bus_oe_o) else $error("bus driven while idle");
  a_top_zero: assert property (host_data_bus_oe_o &&
    $past(host_reg_select_i, 3) == plp_pkg::SEL_PALETTE |->
    host_data_bus_o[7:6] == plp_pkg::TOP_ZERO) else $error("top bits set");
  // Main scenarios
  c_refused: cover property (pixel_valid_i && !pixel_ready_o);
  c_read: cover property ($rose(host_data_bus_oe_o));
  c_stall: cover property (color_valid_o && !color_ready_i);
endmodule

bind plp_top plp_checker u_plp_checker (.*);

// >>> dv/plp_sink.sv
`timescale 1ns/1ps
// Colour consumer: random stalls, or none taken while hold_i is high
module plp_sink (
  input  wire logic clock_i,
  input  wire logic hold_i,
  output logic      ready_o
);
  logic [7:0] lf_q = 8'h5b;
  logic       rdy_q = 1'b0;
  // Moves off the sampling edge
  always @(negedge clock_i) begin
    lf_q <= {lf_q[6:0], lf_q[7] ^ lf_q[5] ^ lf_q[4] ^ lf_q[3]};
    rdy_q <= !hold_i && (lf_q[1:0] != 2'h0);
  end
  assign ready_o = rdy_q;
endmodule

// >>> dv/palette_lookup_ports_bench.sv
`timescale 1ns/1ps
module palette_lookup_ports_bench;
  logic                clock_i = 1'b1;
  logic                resetn_i, video_suppress_n_i, pixel_valid_i, hold;
  logic                pixel_ready_o, color_valid_o, color_ready_i;
  logic                host_rd_n_i, host_wr_n_i, host_data_bus_oe_o;
  logic [1:0]          host_reg_select_i;
  logic [7:0]          pixel_index_i, host_data_bus_i, host_data_bus_o;
  logic [7:0]          drv, mask;
  logic [31:0]         rs = 32'ha57a, r32;
  plp_pkg::plp_color_s color_o;
  plp_pkg::plp_color_s pal [256];
  plp_pkg::plp_color_s exp_q [$];
  int                  err_count, num_checks, cycles, i, c;

  // Device, consumer and the resolved data bus
  plp_top u_plp_top (.*);
  plp_sink u_plp_sink (.clock_i, .hold_i(hold), .ready_o(color_ready_i));
  assign host_data_bus_i = host_data_bus_oe_o ? host_data_bus_o : drv;

  // Clock and cycle ceiling
  initial forever #4 clock_i = ~clock_i;
  always @(posedge clock_i) if (++cycles == 20000) begin
    err_count++;
    stop_test();
  end

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic stop_test();
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check8(string nm, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic check18(plp_pkg::plp_color_s e, plp_pkg::plp_color_s g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH colour exp %h got %h", e, g);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge clock_i);
  endtask

  // Strobes held five cycles low and five high
  task automatic hwr(logic [1:0] s, logic [7:0] d);
    host_reg_select_i = s;
    drv = d;
    host_wr_n_i = 1'b0;
    cyc(5);
    host_wr_n_i = 1'b1;
    cyc(5);
  endtask

  task automatic hrd(logic [1:0] s, logic [7:0] e);
    host_reg_select_i = s;
    host_rd_n_i = 1'b0;
    drv = ~drv;
    cyc(5);
    check8("data", e, host_data_bus_oe_o ? host_data_bus_i : ~e);
    host_rd_n_i = 1'b1;
    cyc(5);
    check8("oe", 8'h00, {7'h0, host_data_bus_oe_o});
  endtask

  // Random offers; refused ones leave no note
  task automatic pixels(int n);
    repeat (n) begin
      @(negedge clock_i);
      r32 = rnd();
      {pixel_valid_i, video_suppress_n_i, pixel_index_i} = r32[9:0];
      if (pixel_valid_i && pixel_ready_o)
        exp_q.push_back(video_suppress_n_i ?
          pal[pixel_index_i & mask] : '0);
    end
    @(negedge clock_i) pixel_valid_i = 1'b0;
  endtask

  // Watcher takes the oldest note for each colour handed over
  // Looks between edges, where head, valid and ready are settled
  always @(negedge clock_i) #1
    if (resetn_i && color_valid_o === 1'b1 && color_ready_i === 1'b1)
      check18(exp_q.size() ? exp_q.pop_front() : 'x, color_o);

  // Main sequence
  initial begin
    {resetn_i, pixel_valid_i, pixel_index_i} = '0;
    {video_suppress_n_i, host_rd_n_i, host_wr_n_i, hold} = 4'he;
    host_reg_select_i = 2'h0;
    drv = 8'h00;
    mask = plp_pkg::MASK_RESET;
    cyc(8);
    resetn_i = 1'b1;
    cyc(2);
    hrd(plp_pkg::SEL_MASK, plp_pkg::MASK_RESET);
    hwr(plp_pkg::SEL_ADDR_WR, 8'h00);
    for (i = 0; i < 256; i++) begin
      r32 = rnd();
      pal[i] = r32[17:0];
      for (c = 0; c < 3; c++)
        hwr(plp_pkg::SEL_PALETTE,
          {r32[31-2*c -: 2], pal[i][17-6*c -: 6]});
    end
    hrd(plp_pkg::SEL_ADDR_RD, 8'h00);
    hwr(plp_pkg::SEL_ADDR_WR, 8'hfe);
    for (i = 254; i < 257; i++)
      for (c = 0; c < 3; c++)
        hrd(plp_pkg::SEL_PALETTE, {2'h0, pal[i[7:0]][17-6*c -: 6]});
    hrd(plp_pkg::SEL_ADDR_RD, 8'h01);
    pixels(300);
    hwr(plp_pkg::SEL_MASK, 8'h3c);
    mask = 8'h3c;
    hrd(plp_pkg::SEL_MASK, 8'h3c);
    hold = 1'b1;
    pixels(30);
    check8("ready", 8'h00, {7'h0, pixel_ready_o});
    hold = 1'b0;
    pixels(300);
    for (i = 0; i < 100 && exp_q.size() > 0; i++) cyc(1);
    check8("left", 8'h00, 8'(exp_q.size()));
    stop_test();
  end
endmodule
